// file: common/amei_pkg.sv
package amei_pkg;
    localparam int NUM_AXES   = 4;
    localparam int POS_W      = 32;
    localparam int DAC_W      = 16;
    localparam int ADC_W      = 16;
    localparam int GEN_IN_W   = 8;
    localparam int GEN_SEL_W  = 3;
    localparam int AXIS_SEL_W = 2;

    // Timing
    localparam int CLK_FREQ_MHZ       = 50;
    localparam int QUAD_RATE_MHZ      = 12;
    localparam int CLK_PER_QUAD_STATE = CLK_FREQ_MHZ / QUAD_RATE_MHZ;
    localparam int STEP_PULSE_NS      = 160;
    localparam int STEP_PULSE_CYCLES  = (STEP_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int STEP_CNT_W         = 5;
    localparam int WDOG_TIMEOUT_US    = 10000;
    localparam int WDOG_TIMEOUT_CYC   = WDOG_TIMEOUT_US * CLK_FREQ_MHZ;
    localparam int WDOG_CNT_W         = 20;

    // Reset values
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [DAC_W-1:0] DAC_RESET = 16'h0000;

    typedef enum logic [1:0] {
        WD_POWERUP,
        WD_RUN,
        WD_FAULT
    } amei_wd_e;
endpackage

// file: common/amei_enc_if.sv
`timescale 1ns/1ns
interface amei_enc_if;
    logic [amei_pkg::POS_W-1:0] pos;
    logic [amei_pkg::POS_W-1:0] index_pos;
    logic                       index_seen;
    logic                       index_clr;
    logic                       bad_step;
    logic                       level_a;
    logic                       level_b;

    modport dec  (output pos, output index_pos, output index_seen, output bad_step,
                  output level_a, output level_b, input index_clr);
    modport user (input pos, input index_pos, input index_seen, input bad_step,
                  input level_a, input level_b, output index_clr);
endinterface

// file: logic/amei_enc_decoder.sv
`timescale 1ns/1ns
module amei_enc_decoder (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    // Encoder pins
    input  wire logic   phase_a,
    input  wire logic   phase_b,
    input  wire logic   index,
    // Mode
    input  wire logic   pulse_dir_mode,
    // Results
    amei_enc_if.dec     enc
);
    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    logic [1:0] i_sync_q;
    logic       a_q;
    logic       b_q;
    logic       i_q;
    logic       step_up;
    logic       step_dn;
    logic       idx_rise;
    logic [amei_pkg::POS_W-1:0] pos_q;
    logic [amei_pkg::POS_W-1:0] pos_d;

    // Two stages before any logic sees the pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
            i_sync_q <= 2'h0;
            a_q      <= 1'b0;
            b_q      <= 1'b0;
            i_q      <= 1'b0;
        end else begin
            a_sync_q <= {a_sync_q[0], phase_a};
            b_sync_q <= {b_sync_q[0], phase_b};
            i_sync_q <= {i_sync_q[0], index};
            a_q      <= a_sync_q[1];
            b_q      <= b_sync_q[1];
            i_q      <= i_sync_q[1];
        end
    end

    // Every quadrature edge counts; four counts per cycle
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (pulse_dir_mode) begin
            if (a_sync_q[1] && !a_q) begin
                step_up = !b_sync_q[1];
                step_dn = b_sync_q[1];
            end
        end else if ((a_sync_q[1] ^ a_q) != (b_sync_q[1] ^ b_q)) begin
            step_up = a_q ^ b_sync_q[1];
            step_dn = !(a_q ^ b_sync_q[1]);
        end
    end

    // 50 MHz sampling leaves four clocks per state at full rate
    always_comb begin
        pos_d = pos_q;
        if (step_up) begin
            pos_d = pos_q + 32'h0000_0001;
        end else if (step_dn) begin
            pos_d = pos_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_q <= amei_pkg::POS_RESET;
        end else begin
            pos_q <= pos_d;
        end
    end

    // Both phases moving at once cannot be resolved
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enc.bad_step <= 1'b0;
        end else begin
            enc.bad_step <= !pulse_dir_mode && (a_sync_q[1] ^ a_q) && (b_sync_q[1] ^ b_q);
        end
    end

    assign idx_rise = i_sync_q[1] && !i_q;

    // Index marks a reference position; a new mark beats a clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enc.index_pos  <= amei_pkg::POS_RESET;
            enc.index_seen <= 1'b0;
        end else begin
            if (idx_rise) begin
                enc.index_pos  <= pos_d;
                enc.index_seen <= 1'b1;
            end else if (enc.index_clr) begin
                enc.index_seen <= 1'b0;
            end
        end
    end

    assign enc.pos     = pos_q;
    assign enc.level_a = a_q;
    assign enc.level_b = b_q;
endmodule // amei_enc_decoder

// file: logic/amei_axis_top.sv
`timescale 1ns/1ns
module amei_axis_top #(
    parameter int WDOG_TIMEOUT = amei_pkg::WDOG_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                                                   CLK,
    input  wire logic                                                   RST_B,
    // Main encoders
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          ENCODER_PHASE_A,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          ENCODER_PHASE_B,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          ENCODER_INDEX,
    // Auxiliary encoders
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          AUX_PHASE_A,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          AUX_PHASE_B,
    // Feedback configuration
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          PULSE_DIR_MAIN,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          PULSE_DIR_AUX,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          AUX_IN_USE,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          ANALOG_FEEDBACK_SELECT,
    input  wire logic [amei_pkg::NUM_AXES-1:0][amei_pkg::ADC_W-1:0]     ANALOG_POSITION,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          INDEX_CLEAR,
    // Feedback results
    output logic      [amei_pkg::NUM_AXES-1:0][amei_pkg::POS_W-1:0]     AXIS_POSITION,
    output logic      [amei_pkg::NUM_AXES-1:0][amei_pkg::POS_W-1:0]     AUX_POSITION,
    output logic      [amei_pkg::NUM_AXES-1:0][amei_pkg::POS_W-1:0]     INDEX_POSITION,
    output logic      [amei_pkg::NUM_AXES-1:0]                          INDEX_SEEN,
    output logic      [amei_pkg::NUM_AXES-1:0]                          ENCODER_FAULT,
    output logic      [amei_pkg::NUM_AXES-1:0][1:0]                     AUX_GP_IN,
    // Position latch
    input  wire logic [amei_pkg::GEN_IN_W-1:0]                          GENERAL_IN,
    input  wire logic                                                   LATCH_ARM,
    input  wire logic [amei_pkg::GEN_SEL_W-1:0]                         LATCH_SELECT,
    output logic                                                        LATCH_DONE,
    output logic      [amei_pkg::NUM_AXES-1:0][amei_pkg::POS_W-1:0]     LATCH_POSITION,
    // Servo commands
    input  wire logic [amei_pkg::NUM_AXES-1:0][amei_pkg::DAC_W-1:0]     MOTOR_COMMAND,
    input  wire logic                                                   SINE_ENABLE,
    input  wire logic [amei_pkg::AXIS_SEL_W-1:0]                        SINE_AXIS,
    input  wire logic [amei_pkg::DAC_W-1:0]                             SINE_COMMAND_B,
    output logic      [amei_pkg::NUM_AXES-1:0][amei_pkg::DAC_W-1:0]     DAC_CODE,
    // Stepper
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          STEPPER_SELECT_JUMPER,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          STEPPER_MODE,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          STEP_REQUEST,
    input  wire logic [amei_pkg::NUM_AXES-1:0]                          STEP_DIRECTION,
    output logic      [amei_pkg::NUM_AXES-1:0]                          STEP_BUSY,
    output logic      [amei_pkg::NUM_AXES-1:0]                          STEP_OUT,
    output logic      [amei_pkg::NUM_AXES-1:0]                          DIRECTION_OUT,
    // Watchdog
    input  wire logic                                                   WATCHDOG_KICK,
    output logic                                                        AMPLIFIER_ENABLE_OUT,
    output logic      [amei_pkg::NUM_AXES-1:0]                          ERROR_LED
);
    localparam int NA = amei_pkg::NUM_AXES;
    localparam int WDOG_CNT_W_L = amei_pkg::WDOG_CNT_W;
    localparam logic [WDOG_CNT_W_L-1:0] WDOG_LAST = WDOG_CNT_W_L'(WDOG_TIMEOUT - 1);
    localparam logic [amei_pkg::STEP_CNT_W-1:0] STEP_HI =
        amei_pkg::STEP_CNT_W'(amei_pkg::STEP_PULSE_CYCLES);
    localparam logic [amei_pkg::STEP_CNT_W-1:0] STEP_ALL =
        amei_pkg::STEP_CNT_W'(2 * amei_pkg::STEP_PULSE_CYCLES);
    localparam logic [amei_pkg::AXIS_SEL_W-1:0] LAST_DAC = amei_pkg::AXIS_SEL_W'(NA - 1);

    logic [1:0][NA-1:0]                       jmp_sync_q;
    logic [NA-1:0]                            stepper_on;
    logic [1:0][amei_pkg::GEN_IN_W-1:0]       gin_sync_q;
    logic                                     sel_in_q;
    logic                                     latch_fire;
    logic [NA-1:0][amei_pkg::POS_W-1:0]       src_pos;
    logic                                     amp_ok;
    logic [WDOG_CNT_W_L-1:0]                  wd_cnt_q;
    amei_pkg::amei_wd_e                       wd_state_q;

    amei_enc_if main_if [NA] ();
    amei_enc_if aux_if  [NA] ();

    // Jumpers are pins; resynchronise before use
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            jmp_sync_q <= '0;
        end else begin
            jmp_sync_q <= {jmp_sync_q[0], STEPPER_SELECT_JUMPER};
        end
    end

    assign stepper_on = jmp_sync_q[1] & STEPPER_MODE;

    genvar g;
    generate
        for (g = 0; g < NA; g++) begin : g_axis
            logic [amei_pkg::STEP_CNT_W-1:0] stp_cnt_q;
            logic [amei_pkg::DAC_W-1:0]      dac_d;

            amei_enc_decoder u_main (
                .clk            (CLK),
                .rst_b          (RST_B),
                .phase_a        (ENCODER_PHASE_A[g]),
                .phase_b        (ENCODER_PHASE_B[g]),
                .index          (ENCODER_INDEX[g]),
                .pulse_dir_mode (PULSE_DIR_MAIN[g]),
                .enc            (main_if[g])
            );

            amei_enc_decoder u_aux (
                .clk            (CLK),
                .rst_b          (RST_B),
                .phase_a        (AUX_PHASE_A[g]),
                .phase_b        (AUX_PHASE_B[g]),
                .index          (1'b0),
                .pulse_dir_mode (PULSE_DIR_AUX[g]),
                .enc            (aux_if[g])
            );

            assign main_if[g].index_clr = INDEX_CLEAR[g];
            assign aux_if[g].index_clr  = 1'b0;
            assign INDEX_POSITION[g]    = main_if[g].index_pos;
            assign INDEX_SEEN[g]        = main_if[g].index_seen;
            assign ENCODER_FAULT[g]     = main_if[g].bad_step | aux_if[g].bad_step;
            assign AUX_POSITION[g]      = aux_if[g].pos;

            // Analog source is sign-extended ADC reading
            assign src_pos[g] = ANALOG_FEEDBACK_SELECT[g] ?
                {{(amei_pkg::POS_W - amei_pkg::ADC_W){ANALOG_POSITION[g][amei_pkg::ADC_W-1]}},
                 ANALOG_POSITION[g]} : main_if[g].pos;

            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    AXIS_POSITION[g] <= amei_pkg::POS_RESET;
                end else begin
                    AXIS_POSITION[g] <= src_pos[g];
                end
            end

            // Aux lines double as general inputs when free
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    AUX_GP_IN[g] <= 2'h0;
                end else if (!AUX_IN_USE[g] && !stepper_on[g]) begin
                    AUX_GP_IN[g] <= {aux_if[g].level_b, aux_if[g].level_a};
                end else begin
                    AUX_GP_IN[g] <= 2'h0;
                end
            end

            // Step pulse: high then low for equal time, caps step rate
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    stp_cnt_q        <= '0;
                    STEP_OUT[g]      <= 1'b0;
                    DIRECTION_OUT[g] <= 1'b0;
                end else if (!stepper_on[g] || !amp_ok) begin
                    stp_cnt_q   <= '0;
                    STEP_OUT[g] <= 1'b0;
                end else if (stp_cnt_q != '0) begin
                    stp_cnt_q <= stp_cnt_q - 1'b1;
                    if (stp_cnt_q == STEP_HI) begin
                        STEP_OUT[g] <= 1'b0;
                    end
                end else if (STEP_REQUEST[g]) begin
                    stp_cnt_q        <= STEP_ALL - 1'b1;
                    STEP_OUT[g]      <= 1'b1;
                    DIRECTION_OUT[g] <= STEP_DIRECTION[g];
                end
            end

            assign STEP_BUSY[g] = stp_cnt_q != '0;

            // DAC selection; a disabled amplifier gets zero
            always_comb begin
                dac_d = MOTOR_COMMAND[g];
                if (SINE_ENABLE && (SINE_AXIS != LAST_DAC) &&
                    (amei_pkg::AXIS_SEL_W'(g) == LAST_DAC)) begin
                    dac_d = SINE_COMMAND_B;
                end
                if (stepper_on[g] || !amp_ok) begin
                    dac_d = amei_pkg::DAC_RESET;
                end
            end

            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    DAC_CODE[g] <= amei_pkg::DAC_RESET;
                end else begin
                    DAC_CODE[g] <= dac_d;
                end
            end
        end
    endgenerate

    // General inputs are pins; two stages then an edge register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gin_sync_q <= '0;
            sel_in_q   <= 1'b0;
        end else begin
            gin_sync_q <= {gin_sync_q[0], GENERAL_IN};
            sel_in_q   <= gin_sync_q[1][LATCH_SELECT];
        end
    end

    // Inputs are active low, so the falling edge fires
    assign latch_fire = LATCH_ARM && !LATCH_DONE && sel_in_q && !gin_sync_q[1][LATCH_SELECT];

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            LATCH_DONE     <= 1'b0;
            LATCH_POSITION <= '0;
        end else if (!LATCH_ARM) begin
            LATCH_DONE <= 1'b0;
        end else if (latch_fire) begin
            LATCH_DONE     <= 1'b1;
            LATCH_POSITION <= src_pos;
        end
    end

    // Watchdog: enable only after the first kick, fault is final
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wd_state_q <= amei_pkg::WD_POWERUP;
            wd_cnt_q   <= '0;
        end else begin
            unique case (wd_state_q)
                amei_pkg::WD_POWERUP: begin
                    if (WATCHDOG_KICK) begin
                        wd_state_q <= amei_pkg::WD_RUN;
                        wd_cnt_q   <= '0;
                    end
                end
                amei_pkg::WD_RUN: begin
                    if (WATCHDOG_KICK) begin
                        wd_cnt_q <= '0;
                    end else if (wd_cnt_q == WDOG_LAST) begin
                        wd_state_q <= amei_pkg::WD_FAULT;
                    end else begin
                        wd_cnt_q <= wd_cnt_q + 1'b1;
                    end
                end
                amei_pkg::WD_FAULT: begin
                    wd_state_q <= amei_pkg::WD_FAULT;
                end
                default: begin
                    wd_state_q <= amei_pkg::WD_FAULT;
                end
            endcase
        end
    end

    assign amp_ok = wd_state_q == amei_pkg::WD_RUN;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            AMPLIFIER_ENABLE_OUT <= 1'b0;
            ERROR_LED            <= '0;
        end else begin
            AMPLIFIER_ENABLE_OUT <= amp_ok;
            ERROR_LED            <= {NA{wd_state_q == amei_pkg::WD_FAULT}};
        end
    end
endmodule // amei_axis_top

// file: tb/amei_axis_props.sv
`timescale 1ns/1ns
module amei_axis_props #(
    parameter int WDOG_TIMEOUT = 50,
    parameter int NA           = amei_pkg::NUM_AXES,
    parameter int DW           = amei_pkg::DAC_W,
    parameter int AW           = amei_pkg::ADC_W,
    parameter int PW           = amei_pkg::POS_W
) (
    // Clock and reset
    input wire logic                  CLK,
    input wire logic                  RST_B,
    // Watchdog
    input wire logic                  WATCHDOG_KICK,
    input wire logic                  AMPLIFIER_ENABLE_OUT,
    input wire logic [NA-1:0]         ERROR_LED,
    // Stepper
    input wire logic [NA-1:0]         STEPPER_MODE,
    input wire logic [NA-1:0]         STEP_REQUEST,
    input wire logic [NA-1:0]         STEP_OUT,
    // Commands
    input wire logic [NA-1:0][DW-1:0] MOTOR_COMMAND,
    input wire logic                  SINE_ENABLE,
    input wire logic [1:0]            SINE_AXIS,
    input wire logic [DW-1:0]         SINE_COMMAND_B,
    input wire logic [NA-1:0][DW-1:0] DAC_CODE,
    // Feedback
    input wire logic [NA-1:0]         ANALOG_FEEDBACK_SELECT,
    input wire logic [NA-1:0][AW-1:0] ANALOG_POSITION,
    input wire logic [NA-1:0][PW-1:0] AXIS_POSITION,
    input wire logic [NA-1:0]         AUX_IN_USE,
    input wire logic [NA-1:0][1:0]    AUX_GP_IN,
    // Latch
    input wire logic                  LATCH_ARM,
    input wire logic                  LATCH_DONE,
    input wire logic [NA-1:0][PW-1:0] LATCH_POSITION
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_step_high;
        STEP_OUT[0] [*8] ##1 !STEP_OUT[0];
    endsequence
    sequence s_fault_state;
        !AMPLIFIER_ENABLE_OUT && ERROR_LED == '1;
    endsequence

    amp_fault_a: assert property ($fell(AMPLIFIER_ENABLE_OUT) |-> ERROR_LED == '1)
        else $error("no error lights");
    fault_hold_a: assert property (ERROR_LED[0] |-> s_fault_state ##1 s_fault_state)
        else $error("fault not held");
    enable_kick_a: assert property ($rose(AMPLIFIER_ENABLE_OUT) |-> $past(WATCHDOG_KICK, 2))
        else $error("enable rose without a kick");
    step_width_a: assert property ($rose(STEP_OUT[0]) |-> s_step_high)
        else $error("step width");
    step_cause_a: assert property ($rose(STEP_OUT[0]) |-> $past(STEP_REQUEST[0]) &&
        $past(STEPPER_MODE[0]) && $past(AMPLIFIER_ENABLE_OUT))
        else $error("step without cause");
    dac_servo_a: assert property ($past(AMPLIFIER_ENABLE_OUT) && AMPLIFIER_ENABLE_OUT &&
        !$past(STEPPER_MODE[1]) |-> DAC_CODE[1] == $past(MOTOR_COMMAND[1]))
        else $error("servo code lost");
    dac_sine_a: assert property ($past(SINE_ENABLE) && $past(SINE_AXIS) != 2'h3 &&
        $past(AMPLIFIER_ENABLE_OUT) && AMPLIFIER_ENABLE_OUT && !$past(STEPPER_MODE[3])
        |-> DAC_CODE[3] == $past(SINE_COMMAND_B))
        else $error("second sine phase missing");
    analog_fb_a: assert property ($past(ANALOG_FEEDBACK_SELECT[2]) |-> AXIS_POSITION[2] ==
        {{16{$past(ANALOG_POSITION[2][15])}}, $past(ANALOG_POSITION[2])})
        else $error("analog position wrong");
    aux_gp_a: assert property ($past(AUX_IN_USE[2]) |-> AUX_GP_IN[2] == 2'h0)
        else $error("aux lines shown");
    latch_hold_a: assert property (LATCH_DONE && LATCH_ARM |=> LATCH_DONE && $stable(LATCH_POSITION))
        else $error("latch changed");
endmodule // amei_axis_props

bind amei_axis_top amei_axis_props #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) u_props (
    .CLK(CLK), .RST_B(RST_B), .WATCHDOG_KICK(WATCHDOG_KICK), .AMPLIFIER_ENABLE_OUT(AMPLIFIER_ENABLE_OUT),
    .ERROR_LED(ERROR_LED), .STEPPER_MODE(STEPPER_MODE), .STEP_REQUEST(STEP_REQUEST), .STEP_OUT(STEP_OUT),
    .MOTOR_COMMAND(MOTOR_COMMAND), .SINE_ENABLE(SINE_ENABLE), .SINE_AXIS(SINE_AXIS),
    .SINE_COMMAND_B(SINE_COMMAND_B), .DAC_CODE(DAC_CODE), .ANALOG_FEEDBACK_SELECT(ANALOG_FEEDBACK_SELECT),
    .ANALOG_POSITION(ANALOG_POSITION), .AXIS_POSITION(AXIS_POSITION), .AUX_IN_USE(AUX_IN_USE),
    .AUX_GP_IN(AUX_GP_IN), .LATCH_ARM(LATCH_ARM), .LATCH_DONE(LATCH_DONE), .LATCH_POSITION(LATCH_POSITION)
);

// file: tb/amei_enc_model.sv
`timescale 1ns/1ns
module amei_enc_model #(
    parameter int N = 4
) (
    // Clock
    input  wire logic         clk,
    // Commands
    input  wire logic [N-1:0] move,
    input  wire logic [N-1:0] dir,
    input  wire logic [N-1:0] pd,
    // Encoder lines
    output logic      [N-1:0] ph_a,
    output logic      [N-1:0] ph_b
);
    initial begin
        ph_a = '0;
        ph_b = '0;
    end
    // One state change per move; spacing is up to the caller
    always @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            if (pd[i]) begin
                ph_b[i] <= dir[i];
                if (move[i])
                    ph_a[i] <= ~ph_a[i];
            end else if (move[i]) begin
                ph_a[i] <= dir[i] ? ~ph_b[i] : ph_b[i];
                ph_b[i] <= dir[i] ? ph_a[i] : ~ph_a[i];
            end
        end
    end
endmodule // amei_enc_model

// file: tb/tb_axis_motor_encoder_interface.sv
`timescale 1ns/1ns
module tb_axis_motor_encoder_interface;
    localparam int N  = amei_pkg::NUM_AXES;
    localparam int WD = 50;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [N-1:0] mv_m = '0, dir_m = '0, pd_m = '0, mv_x = '0, dir_x = '0;
    logic [N-1:0] enc_a, enc_b, aux_a, aux_b;
    logic [N-1:0] idx = '0, aux_use = '0, afs = '0, iclr = '0, jmp = '0, smode = '0, sreq = '0, sdir = '0;
    logic [N-1:0][amei_pkg::ADC_W-1:0] apos = '0;
    logic [N-1:0][amei_pkg::DAC_W-1:0] mcmd = '0;
    logic [7:0] gin = 8'hff;
    logic [2:0] lsel = 3'h0;
    logic [1:0] saxis = 2'h0;
    logic [15:0] scmd = 16'h0;
    logic arm = 1'b0, sen = 1'b0, kick = 1'b0, kick_en = 1'b0;
    logic [3:0] kcnt = 4'h0;
    logic [N-1:0][amei_pkg::POS_W-1:0] axpos, auxpos, ipos, lpos;
    logic [N-1:0][amei_pkg::DAC_W-1:0] dac;
    logic [N-1:0][1:0] gp;
    logic [N-1:0] iseen, sout, dout, led, busy;
    logic ldone, amp;
    int err_total = 0;
    int num_checks = 0;

    always #10 clk = ~clk;
    always @(posedge clk) begin
        kcnt <= kcnt + 4'h1;
        kick <= kick_en && (kcnt == 4'hf);
    end

    amei_enc_model #(.N(N)) u_main (.clk(clk), .move(mv_m), .dir(dir_m), .pd(pd_m), .ph_a(enc_a), .ph_b(enc_b));
    amei_enc_model #(.N(N)) u_aux (.clk(clk), .move(mv_x), .dir(dir_x), .pd('0), .ph_a(aux_a), .ph_b(aux_b));
    amei_axis_top #(.WDOG_TIMEOUT(WD)) u_dut (
        .CLK(clk), .RST_B(rst_b), .ENCODER_PHASE_A(enc_a), .ENCODER_PHASE_B(enc_b), .ENCODER_INDEX(idx),
        .AUX_PHASE_A(aux_a), .AUX_PHASE_B(aux_b), .PULSE_DIR_MAIN(pd_m), .PULSE_DIR_AUX('0),
        .AUX_IN_USE(aux_use), .ANALOG_FEEDBACK_SELECT(afs), .ANALOG_POSITION(apos), .INDEX_CLEAR(iclr),
        .AXIS_POSITION(axpos), .AUX_POSITION(auxpos), .INDEX_POSITION(ipos), .INDEX_SEEN(iseen),
        .ENCODER_FAULT(), .AUX_GP_IN(gp), .GENERAL_IN(gin), .LATCH_ARM(arm), .LATCH_SELECT(lsel),
        .LATCH_DONE(ldone), .LATCH_POSITION(lpos), .MOTOR_COMMAND(mcmd), .SINE_ENABLE(sen),
        .SINE_AXIS(saxis), .SINE_COMMAND_B(scmd), .DAC_CODE(dac), .STEPPER_SELECT_JUMPER(jmp),
        .STEPPER_MODE(smode), .STEP_REQUEST(sreq), .STEP_DIRECTION(sdir), .STEP_BUSY(busy), .STEP_OUT(sout),
        .DIRECTION_OUT(dout), .WATCHDOG_KICK(kick), .AMPLIFIER_ENABLE_OUT(amp), .ERROR_LED(led)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Direction settles one edge before the move
    task automatic mv(input int ax, input logic d, input int n, input logic aux);
        dir_m[ax] <= d;
        dir_x[ax] <= d;
        cyc(1);
        repeat (n) begin
            if (aux) mv_x[ax] <= 1'b1;
            else mv_m[ax] <= 1'b1;
            cyc(1);
            mv_m <= '0;
            mv_x <= '0;
            cyc(4);
        end
        cyc(6);
        #1;
    endtask

    task automatic t_power;
        cyc(4);
        #1 chk(32'(amp), 32'h0);
        kick_en <= 1'b1;
        for (int i = 0; i < 40 && amp !== 1'b1; i++) cyc(1);
        #1 chk(32'(amp), 32'h1);
        chk(32'(led), 32'h0);
        $display("power done");
    endtask
    task automatic t_quad;
        mv(0, 1'b0, 8, 1'b0);
        chk(axpos[0], 32'h8);
        mv(0, 1'b1, 4, 1'b0);
        chk(axpos[0], 32'h4);
        pd_m[1] <= 1'b1;
        mv(1, 1'b1, 6, 1'b0);
        chk(axpos[1], 32'hffff_fffd);
        $display("quad done");
    endtask
    task automatic t_aux;
        aux_use[2] <= 1'b1;
        mv(2, 1'b0, 4, 1'b1);
        chk(auxpos[2], 32'h4);
        chk(axpos[2], 32'h0);
        chk(32'(gp[2]), 32'h0);
        mv(3, 1'b0, 1, 1'b1);
        chk(32'(gp[3]), 32'h2);
        $display("aux done");
    endtask
    task automatic t_index;
        idx[0] <= 1'b1;
        cyc(6);
        #1 chk(32'(iseen[0]), 32'h1);
        chk(ipos[0], 32'h4);
        idx[0] <= 1'b0;
        iclr[0] <= 1'b1;
        cyc(1);
        iclr[0] <= 1'b0;
        cyc(2);
        #1 chk(32'(iseen[0]), 32'h0);
        $display("index done");
    endtask
    task automatic t_latch;
        lsel <= 3'h5;
        arm <= 1'b1;
        cyc(2);
        gin[5] <= 1'b0;
        for (int i = 0; i < 10 && ldone !== 1'b1; i++) cyc(1);
        #1 chk(32'(ldone), 32'h1);
        chk(lpos[0], 32'h4);
        chk(lpos[1], 32'hffff_fffd);
        gin[5] <= 1'b1;
        arm <= 1'b0;
        cyc(3);
        #1 chk(32'(ldone), 32'h0);
        $display("latch done");
    endtask
    task automatic t_dac;
        mcmd[0] <= 16'h0100;
        mcmd[1] <= 16'h8001;
        sen <= 1'b1;
        scmd <= 16'h7ffe;
        cyc(3);
        #1 chk(32'(dac[1]), 32'h8001);
        chk(32'(dac[0]), 32'h0100);
        chk(32'(dac[3]), 32'h7ffe);
        sen <= 1'b0;
        $display("dac done");
    endtask
    task automatic t_step;
        int hi0;
        int hi1;
        int hb;
        hi0 = 0;
        hi1 = 0;
        hb = 0;
        jmp[0] <= 1'b1;
        smode <= 4'h3;
        cyc(5);
        sdir <= 4'h3;
        sreq <= 4'h3;
        cyc(1);
        sreq <= '0;
        repeat (20) begin
            #1;
            if (sout[0] === 1'b1) hi0++;
            if (sout[1] === 1'b1) hi1++;
            if (busy[0] === 1'b1) hb++;
            cyc(1);
        end
        chk(32'(hi0), 32'h8);
        chk(32'(hb), 32'hf);
        chk(32'(hi1), 32'h0);
        chk(32'(dout[0]), 32'h1);
        chk(32'(dac[0]), 32'h0);
        smode <= '0;
        jmp <= '0;
        $display("step done");
    endtask
    task automatic t_analog;
        afs[2] <= 1'b1;
        apos[2] <= 16'hfff0;
        cyc(3);
        #1 chk(axpos[2], 32'hffff_fff0);
        afs[2] <= 1'b0;
        $display("analog done");
    endtask
    task automatic t_wdog;
        kick_en <= 1'b0;
        cyc(WD + 25);
        #1 chk(32'(amp), 32'h0);
        chk(32'(led), 32'hf);
        kick_en <= 1'b1;
        cyc(40);
        #1 chk(32'(amp), 32'h0);
        kick_en <= 1'b0;
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cyc(2);
        #1 chk(32'(amp), 32'h0);
        kick_en <= 1'b1;
        cyc(40);
        #1 chk(32'(amp), 32'h1);
        chk(32'(led), 32'h0);
        $display("watchdog done");
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Run needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        end_sim();
    end
    initial begin
        cyc(16);
        rst_b <= 1'b1;
        t_power();
        t_quad();
        t_aux();
        t_index();
        t_latch();
        t_dac();
        t_step();
        t_analog();
        t_wdog();
        end_sim();
    end
endmodule // tb_axis_motor_encoder_interface
